//--- core/cod_pkg.sv
// Constants and types shared by the clock output divider files.
package cod_pkg;

  // --------------------------------------------------------------------------
  // Divide select encoding
  // --------------------------------------------------------------------------

  // Two-bit divide select; the reset value gives the quarter rate.
  typedef enum logic [1:0] {
    COD_QUARTER = 2'h0,
    COD_HALF = 2'h1,
    COD_FULL = 2'h2,
    COD_OFF = 2'h3
  } cod_sel_t;

  // Bit positions of the divide select inside the control word.
  localparam int COD_SEL_LSB = 0;
  localparam int COD_SEL_MSB = 1;

  // Value taken by the divide select during and after reset.
  localparam cod_sel_t COD_SEL_RESET = COD_QUARTER;

  // --------------------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------------------

  // System clock period in nanoseconds.
  localparam int COD_SYS_PERIOD_NS = 10;

  // Output pin toggles once per this many system clock cycles.
  localparam logic [1:0] COD_HALF_TOGGLE_CYCLES = 2'h1;
  localparam logic [1:0] COD_QUARTER_TOGGLE_CYCLES = 2'h2;

  // Reset values of the output flip-flops and of the toggle counter.
  localparam logic COD_PIN_RESET = 1'b0;
  localparam logic COD_OE_RESET = 1'b1;
  localparam logic COD_FULL_EN_RESET = 1'b0;
  localparam logic [1:0] COD_COUNT_RESET = 2'h0;

  // --------------------------------------------------------------------------
  // Carrier
  // --------------------------------------------------------------------------

  // Control word write: a one-cycle valid with the new divide select.
  typedef struct packed {
    logic valid;
    cod_sel_t sel;
  } cod_wr_t;

endpackage : cod_pkg

//--- core/cod_toggle_timer.sv
// Toggle timer that marks the cycles on which the divided clock changes level.
module cod_toggle_timer (
  input wire logic i_clk_sys,
  input wire logic i_srst,
  input wire logic i_restart,
  input wire logic [1:0] i_period,
  output logic o_tick
);
  import cod_pkg::*;

  logic [1:0] count;
  logic [1:0] last_count;

  // Terminal count is one below the period, so a period of one ticks every cycle.
  assign last_count = i_period - 2'h1;

  // --------------------------------------------------------------------------
  // Counter
  // --------------------------------------------------------------------------

  // A restart lines the counter up with a fresh select so the first half period is whole.
  always_ff @(posedge i_clk_sys) begin
    if (i_srst || i_restart) begin
      count <= COD_COUNT_RESET;
    end else if (count >= last_count) begin
      count <= COD_COUNT_RESET;
    end else begin
      count <= count + 2'h1;
    end
  end

  // The tick is combinational; the consumer registers the pin it steers.
  assign o_tick = (count >= last_count) && !i_restart;

endmodule : cod_toggle_timer

//--- core/cod_top.sv
// Clock output divider: drives the external clock pin from the system clock.
module cod_top (
  input wire logic i_clk_sys,
  input wire logic i_srst,
  input wire cod_pkg::cod_wr_t i_ctrl_wr,
  output cod_pkg::cod_sel_t o_divide_sel,
  output logic o_clock_out_pin,
  output logic o_clock_out_full_en,
  output logic o_clock_out_oe
);
  import cod_pkg::*;

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------

  cod_sel_t sel;
  logic [1:0] period;
  logic restart;
  logic tick;
  logic next_pin;

  // --------------------------------------------------------------------------
  // Divide select
  // --------------------------------------------------------------------------

  // Control word store; a write from logic on this clock needs no synchroniser.
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      sel <= COD_SEL_RESET;
    end else if (i_ctrl_wr.valid) begin
      sel <= i_ctrl_wr.sel;
    end
  end

  // Readback of the stored select for the control word.
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_divide_sel <= COD_SEL_RESET;
    end else if (i_ctrl_wr.valid) begin
      o_divide_sel <= i_ctrl_wr.sel;
    end
  end

  // --------------------------------------------------------------------------
  // Toggle timing
  // --------------------------------------------------------------------------

  // Half and quarter rates differ only in how many cycles separate two toggles.
  always_comb begin
    case (sel)
      COD_HALF: period = COD_HALF_TOGGLE_CYCLES;
      COD_QUARTER: period = COD_QUARTER_TOGGLE_CYCLES;
      default: period = COD_QUARTER_TOGGLE_CYCLES;
    endcase
  end

  // A new select restarts the phase, trading one short stall for no runt pulse.
  assign restart = i_ctrl_wr.valid;

  cod_toggle_timer u_timer (
    .i_clk_sys(i_clk_sys),
    .i_srst(i_srst),
    .i_restart(restart),
    .i_period(period),
    .o_tick(tick)
  );

  // --------------------------------------------------------------------------
  // Pin level
  // --------------------------------------------------------------------------

  // Divided level; full rate and off both park the divided flop low.
  always_comb begin
    next_pin = o_clock_out_pin;
    case (sel)
      COD_HALF,
      COD_QUARTER: begin
        if (tick) begin
          next_pin = !o_clock_out_pin;
        end
      end
      COD_FULL: next_pin = COD_PIN_RESET;
      COD_OFF: next_pin = COD_PIN_RESET;
      default: next_pin = COD_PIN_RESET;
    endcase
  end

  // Pin flop; a write parks it low so every mode starts from a known level.
  always_ff @(posedge i_clk_sys) begin
    if (i_srst || i_ctrl_wr.valid) begin
      o_clock_out_pin <= COD_PIN_RESET;
    end else begin
      o_clock_out_pin <= next_pin;
    end
  end

  // A single-edge flop cannot toggle at the full rate, so the pad gates the system clock.
  always_ff @(posedge i_clk_sys) begin
    if (i_srst || i_ctrl_wr.valid) begin
      o_clock_out_full_en <= COD_FULL_EN_RESET;
    end else begin
      o_clock_out_full_en <= (sel == COD_FULL);
    end
  end

  // --------------------------------------------------------------------------
  // Pin drive
  // --------------------------------------------------------------------------

  // Unlike general-purpose pins the driver stays on through reset.
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_clock_out_oe <= COD_OE_RESET;
    end else begin
      o_clock_out_oe <= COD_OE_RESET;
    end
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------

  // A settled half-rate select flips the pin on every cycle.
  property p_half_rate;
    @(posedge i_clk_sys) disable iff (i_srst)
      (sel == COD_HALF && !i_ctrl_wr.valid) |=> (o_clock_out_pin != $past(o_clock_out_pin));
  endproperty
  a_half_rate: assert property (p_half_rate)
    else $error("half rate pin did not toggle");

  // Quarter rate: two settled cycles give exactly one toggle, so levels two apart differ.
  sequence s_quarter_run;
    (sel == COD_QUARTER && !i_ctrl_wr.valid && !i_srst) [*2];
  endsequence
  property p_quarter_rate;
    @(posedge i_clk_sys) disable iff (i_srst)
      s_quarter_run |=> (o_clock_out_pin != $past(o_clock_out_pin, 2));
  endproperty
  a_quarter_rate: assert property (p_quarter_rate)
    else $error("quarter rate pin period wrong");

  // Quarter rate must also hold its level for two cycles.
  property p_quarter_hold;
    @(posedge i_clk_sys) disable iff (i_srst)
      (sel == COD_QUARTER && !i_ctrl_wr.valid) ##1 (sel == COD_QUARTER && !i_ctrl_wr.valid)
      |=> ($past(o_clock_out_pin) == o_clock_out_pin) || ($past(o_clock_out_pin, 2)
      == $past(o_clock_out_pin));
  endproperty
  a_quarter_hold: assert property (p_quarter_hold)
    else $error("quarter rate pin toggled on consecutive cycles");

  // Full rate hands the pin to the gated system clock.
  property p_full_rate;
    @(posedge i_clk_sys) disable iff (i_srst)
      (sel == COD_FULL && !i_ctrl_wr.valid) |=> (o_clock_out_full_en && !o_clock_out_pin);
  endproperty
  a_full_rate: assert property (p_full_rate)
    else $error("full rate gate not enabled");

  // Reset leaves the quarter-rate select in place on release.
  property p_reset_sel;
    @(posedge i_clk_sys) i_srst |=> (sel == COD_SEL_RESET && o_divide_sel == COD_QUARTER);
  endproperty
  a_reset_sel: assert property (p_reset_sel)
    else $error("reset did not select quarter rate");

  // The off select keeps the pin quiet for as long as it stands.
  property p_off_quiet;
    @(posedge i_clk_sys) disable iff (i_srst)
      (sel == COD_OFF && !i_ctrl_wr.valid) [*2] |-> (!o_clock_out_pin && !o_clock_out_full_en);
  endproperty
  a_off_quiet: assert property (p_off_quiet)
    else $error("clock output active while off");

  // The driver is on in every cycle after the first edge, reset or not.
  property p_drive_on;
    @(posedge i_clk_sys) ##1 o_clock_out_oe;
  endproperty
  a_drive_on: assert property (p_drive_on)
    else $error("clock pin released");

  // A written full-rate code lands as the same encoding and picks the full-rate mode.
  property p_encoding;
    @(posedge i_clk_sys) disable iff (i_srst)
      (!i_srst && i_ctrl_wr.valid && i_ctrl_wr.sel == COD_FULL) ##1 (!i_ctrl_wr.valid)
      |=> (o_divide_sel == 2'h2 && o_clock_out_full_en);
  endproperty
  a_encoding: assert property (p_encoding)
    else $error("divide select encoding mismatch");

  // An accepted write parks both pin controls and lands in the readback.
  // The reset term is sampled, since the disable condition alone misses the release edge.
  property p_write_park;
    @(posedge i_clk_sys) disable iff (i_srst)
      (i_ctrl_wr.valid && !i_srst) |=> (!o_clock_out_pin && !o_clock_out_full_en
      && o_divide_sel == $past(i_ctrl_wr.sel));
  endproperty
  a_write_park: assert property (p_write_park)
    else $error("write did not restart the clock output");

  // Reset parks the divided level low while the driver stays on.
  property p_reset_quiet;
    @(posedge i_clk_sys) i_srst |=>
      (!o_clock_out_pin && !o_clock_out_full_en && o_clock_out_oe);
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("clock pin not parked and driven in reset");

  // Main scenarios.
  c_half: cover property (@(posedge i_clk_sys) disable iff (i_srst)
    (sel == COD_HALF) [*4]);
  c_quarter_after_reset: cover property (@(posedge i_clk_sys)
    $fell(i_srst) ##1 (sel == COD_QUARTER) [*6]);
  c_full: cover property (@(posedge i_clk_sys) disable iff (i_srst)
    o_clock_out_full_en [*3]);
  c_turn_off: cover property (@(posedge i_clk_sys) disable iff (i_srst)
    (sel == COD_QUARTER) ##1 (i_ctrl_wr.valid && i_ctrl_wr.sel == COD_OFF) ##1 (sel == COD_OFF));
  c_write_in_reset: cover property (@(posedge i_clk_sys)
    (i_srst && i_ctrl_wr.valid) ##1 i_srst);

endmodule : cod_top

//--- test/cod_board_model.sv
// Board-side model that listens to the clock output pad and counts its rising edges.
module cod_board_model (
  input wire logic i_clk_sys,
  input wire logic i_pin,
  input wire logic i_full_en,
  input wire logic i_oe,
  output logic [15:0] o_rise_count,
  output logic o_released
);
  timeunit 1ns;
  timeprecision 1ns;
  logic pad;
  // --------------------------------------------------------------------------
  // Pad level
  // --------------------------------------------------------------------------
  // The pad passes the system clock in full mode and floats when not enabled.
  assign pad = i_oe ? (i_full_en ? i_clk_sys : i_pin) : 1'bz;
  // Start from a known count so the bench can work with differences.
  initial begin
    o_rise_count = 16'h0;
    o_released = 1'b0;
  end
  // Each rising pad edge is one clock period seen by the board.
  always @(posedge pad) begin
    o_rise_count <= o_rise_count + 16'h1;
  end
  // Sticky flag; the first edge is skipped since the enable is unknown before it.
  always @(posedge i_clk_sys) begin
    if (i_oe !== 1'b1 && $time > 10) begin
      o_released <= 1'b1;
    end
  end
endmodule : cod_board_model

//--- test/tb.sv
// Self-checking testbench for the clock output divider.
module tb;
  import cod_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk;
  logic srst;
  cod_wr_t wr;
  cod_sel_t sel;
  logic pin;
  logic full_en;
  logic oe;
  logic [15:0] rises;
  logic released;
  int fails = 0;
  int samples_checked = 0;
  // --------------------------------------------------------------------------
  // Instances
  // --------------------------------------------------------------------------
  cod_top dut_u (.i_clk_sys(clk), .i_srst(srst), .i_ctrl_wr(wr), .o_divide_sel(sel),
    .o_clock_out_pin(pin), .o_clock_out_full_en(full_en), .o_clock_out_oe(oe));
  cod_board_model board_u (.i_clk_sys(clk), .i_pin(pin), .i_full_en(full_en), .i_oe(oe),
    .o_rise_count(rises), .o_released(released));
  // Free-running system clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // --------------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------------
  // Case inequality so an unknown output never passes.
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk
  task automatic conclude;
    $display("Checks %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : conclude
  // One-cycle write; returns one step after the edge that took it.
  task automatic wr_sel(input cod_sel_t s);
    @(posedge clk);
    wr <= '{valid: 1'b1, sel: s};
    @(posedge clk);
    wr <= '{valid: 1'b0, sel: COD_QUARTER};
    #1;
  endtask : wr_sel
  // Follows the pin for n cycles after a write or reset release, k = 1 being the first.
  task automatic watch(input cod_sel_t s, input int n);
    logic [15:0] r0;
    logic ep;
    logic [15:0] edges_exp;
    r0 = rises;
    for (int k = 1; k <= n; k++) begin
      if (k > 1) begin
        @(posedge clk);
        #1;
      end
      if (k == n - 8) r0 = rises;
      ep = (s == COD_HALF) ? ((k - 1) % 2 == 1) :
           (s == COD_QUARTER) ? (((k - 1) / 2) % 2 == 1) : 1'b0;
      chk(16'(pin), 16'(ep), "pin level");
      chk(16'(full_en), 16'(s == COD_FULL && k >= 2), "full enable");
      chk(16'(sel), 16'(s), "divide select");
      chk(16'(oe), 16'h1, "output enable");
    end
    // The board sees 8, 4, 2 or 0 rising edges in eight cycles.
    edges_exp = (s == COD_FULL) ? 16'h8 : (s == COD_HALF) ? 16'h4 :
                (s == COD_QUARTER) ? 16'h2 : 16'h0;
    chk(rises - r0, edges_exp, "edge count");
  endtask : watch
  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  // Pin is held low but driven during reset, then quarter rate starts.
  task automatic t_init;
    for (int c = 1; c <= 6; c++) begin
      @(posedge clk);
      if (c == 6) srst <= 1'b0;
      #1;
      chk(16'(oe), 16'h1, "enable in reset");
      chk(16'(pin), 16'h0, "pin in reset");
      chk(16'(sel), 16'(COD_SEL_RESET), "select in reset");
    end
    watch(COD_QUARTER, 16);
    $display("t_init done");
  endtask : t_init
  task automatic t_half_quarter;
    wr_sel(COD_HALF);
    watch(COD_HALF, 16);
    wr_sel(COD_QUARTER);
    watch(COD_QUARTER, 16);
    $display("t_half_quarter done");
  endtask : t_half_quarter
  task automatic t_full_off;
    wr_sel(COD_OFF);
    watch(COD_OFF, 16);
    wr_sel(COD_FULL);
    watch(COD_FULL, 16);
    wr_sel(COD_OFF);
    watch(COD_OFF, 16);
    $display("t_full_off done");
  endtask : t_full_off
  // Two writes on consecutive edges: the later one wins.
  task automatic t_back_to_back;
    @(posedge clk);
    wr <= '{valid: 1'b1, sel: COD_HALF};
    @(posedge clk);
    wr <= '{valid: 1'b1, sel: COD_FULL};
    @(posedge clk);
    wr <= '{valid: 1'b0, sel: COD_QUARTER};
    #1;
    watch(COD_FULL, 16);
    $display("t_back_to_back done");
  endtask : t_back_to_back
  // Reset in mid-run with a write held through it; the write must be ignored.
  task automatic t_reset_mid;
    wr_sel(COD_HALF);
    watch(COD_HALF, 12);
    @(posedge clk);
    srst <= 1'b1;
    wr <= '{valid: 1'b1, sel: COD_FULL};
    repeat (3) begin
      @(posedge clk);
      #1;
      chk(16'(oe), 16'h1, "enable in reset");
      chk(16'(pin), 16'h0, "pin in reset");
      chk(16'(sel), 16'(COD_SEL_RESET), "select in reset");
    end
    @(posedge clk);
    srst <= 1'b0;
    wr <= '{valid: 1'b0, sel: COD_QUARTER};
    #1;
    watch(COD_QUARTER, 16);
    chk(16'(released), 16'h0, "pad released");
    $display("t_reset_mid done");
  endtask : t_reset_mid
  // --------------------------------------------------------------------------
  // Main sequence and watchdog
  // --------------------------------------------------------------------------
  initial begin
    srst <= 1'b1;
    wr <= '{valid: 1'b0, sel: COD_QUARTER};
    t_init();
    t_half_quarter();
    t_full_off();
    t_back_to_back();
    t_reset_mid();
    conclude();
  end
  // The tests need about 160 cycles; over ten times that means a hang.
  initial begin
    #20000;
    fails++;
    $display("ERROR at %0t: watchdog expired", $time);
    conclude();
  end
endmodule : tb
